// *** design/ipc_pkg.sv ***
// Purpose: constants for the input polarity control register pair
// Assumes: byte-wide registers written and read through an internal byte port
// Notes: offsets are the byte numbers of the management register file
package ipc_pkg;
   localparam logic [7:0] IPC_OFS_OE_POL = 8'h12;
   localparam logic [7:0] IPC_OFS_PD_POL = 8'h13;
   localparam int IPC_BIT_EN1 = 1;
   localparam int IPC_BIT_EN2 = 3;
   localparam int IPC_BIT_EN3 = 5;
   localparam int IPC_BIT_EN4 = 6;
   localparam int IPC_BIT_PD = 0;
   localparam logic [7:0] IPC_OE_POL_RST = 8'h00;
   localparam logic [7:0] IPC_PD_POL_RST = 8'h00;
   localparam logic [7:0] IPC_OE_POL_MASK = 8'h6a;
   localparam logic [7:0] IPC_PD_POL_MASK = 8'h01;
   localparam logic [1:0] IPC_STOP_LOW_LOW = 2'h0;
   localparam logic [1:0] IPC_STOP_HIZ_HIZ = 2'h1;
   localparam logic [1:0] IPC_STOP_HIGH_LOW = 2'h2;
   localparam logic [1:0] IPC_STOP_LOW_HIGH = 2'h3;
   typedef struct packed {
      logic [7:0] oe_pol;
      logic [7:0] pd_pol;
      logic [7:0] rdata;
      logic [3:0] en;
      logic power_down;
      logic [3:0] leg_true;
      logic [3:0] leg_comp;
      logic [3:0] leg_oe_n;
   } ipc_state_t;
endpackage : ipc_pkg

// *** design/ipc_stop_leg.sv ***
// Purpose: level of one differential pair's legs given enable and stop field
// Assumes: clock_in is the running clock level for the pair
// Notes: oe_n low means the leg is driven
`timescale 1ns/1ns
module ipc_stop_leg
   import ipc_pkg::*;
(
   // control
   input wire logic enabled,
   input wire logic [1:0] stop_field,
   input wire logic clock_in,
   // legs
   output logic leg_true,
   output logic leg_comp,
   output logic leg_oe_n
);
   always_comb
   begin
      leg_true = clock_in;
      leg_comp = ~clock_in;
      leg_oe_n = 1'b0;
      if (!enabled)
      begin
         case (stop_field)
            IPC_STOP_LOW_LOW:
            begin
               leg_true = 1'b0;
               leg_comp = 1'b0;
            end
            IPC_STOP_HIZ_HIZ:
            begin
               leg_true = 1'b0;
               leg_comp = 1'b0;
               leg_oe_n = 1'b1;
            end
            IPC_STOP_HIGH_LOW:
            begin
               leg_true = 1'b1;
               leg_comp = 1'b0;
            end
            default:
            begin
               leg_true = 1'b0;
               leg_comp = 1'b1;
            end
         endcase
      end
   end
endmodule : ipc_stop_leg

// *** design/ipc_polarity_regs.sv ***
// Purpose: polarity registers for four output enables and the power-good input
// Assumes: byte port from the serial management engine, inputs synchronous
// Notes: outputs are registered, one clock behind their inputs; the legs trail the enable pins by two
`timescale 1ns/1ns
// Notes on behaviour
// - bit 6 of the enable polarity register makes enable four active high when set.
// - bit 1 of that register makes enable one active high when set.
// - bits 5 and 3 make enables three and two active high when set, reset zero.
// - bit 0 of the power polarity register makes power down happen on a high input when set.
// - a disabled pair drives the legs chosen by the two-bit stop state field.
module ipc_polarity_regs
   import ipc_pkg::*;
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // register byte port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // pins and clock source
   input wire logic output_enable_one,
   input wire logic output_enable_two,
   input wire logic output_enable_three,
   input wire logic output_enable_four,
   input wire logic power_good_power_down_input,
   input wire logic [1:0] disabled_output_state_field,
   input wire logic [3:0] clock_level,
   // results
   output logic [3:0] output_enabled,
   output logic power_down,
   output logic [3:0] differential_clock_output_true,
   output logic [3:0] differential_clock_output_comp,
   output logic [3:0] differential_clock_output_oe_n
);
   import ipc_pkg::*;

   ipc_state_t st_reg;
   ipc_state_t st_next;
   logic [3:0] pin_en;
   logic [3:0] lvl_sel;
   logic [3:0] leg_t;
   logic [3:0] leg_c;
   logic [3:0] leg_z;

   ////////////////////////////////////////////////////////////////////////
   assign pin_en = {output_enable_four, output_enable_three,
                    output_enable_two, output_enable_one};
   assign lvl_sel = {st_reg.oe_pol[IPC_BIT_EN4], st_reg.oe_pol[IPC_BIT_EN3],
                     st_reg.oe_pol[IPC_BIT_EN2], st_reg.oe_pol[IPC_BIT_EN1]};

   // legs follow the registered enable so they never glitch on a pin edge
   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_leg
         ipc_stop_leg u_leg (
            .enabled(st_reg.en[i]),
            .stop_field(disabled_output_state_field),
            .clock_in(clock_level[i]),
            .leg_true(leg_t[i]),
            .leg_comp(leg_c[i]),
            .leg_oe_n(leg_z[i])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      st_next = st_reg;
      if (reg_wr && reg_addr == IPC_OFS_OE_POL)
      begin
         st_next.oe_pol = reg_wdata & IPC_OE_POL_MASK;
      end
      if (reg_wr && reg_addr == IPC_OFS_PD_POL)
      begin
         st_next.pd_pol = reg_wdata & IPC_PD_POL_MASK;
      end
      if (reg_rd)
      begin
         case (reg_addr)
            IPC_OFS_OE_POL: st_next.rdata = st_reg.oe_pol;
            IPC_OFS_PD_POL: st_next.rdata = st_reg.pd_pol;
            default: st_next.rdata = 8'h00;
         endcase
      end
      // xnor: selected level equal to pin means enabled
      st_next.en = ~(pin_en ^ lvl_sel);
      st_next.power_down =
         ~(power_good_power_down_input ^ st_reg.pd_pol[IPC_BIT_PD]);
      st_next.leg_true = leg_t;
      st_next.leg_comp = leg_c;
      st_next.leg_oe_n = leg_z;
      if (!nrst)
      begin
         st_next = '0;
         st_next.oe_pol = IPC_OE_POL_RST;
         st_next.pd_pol = IPC_PD_POL_RST;
         st_next.leg_oe_n = 4'hf;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////////////
   assign reg_rdata = st_reg.rdata;
   assign output_enabled = st_reg.en;
   assign power_down = st_reg.power_down;
   assign differential_clock_output_true = st_reg.leg_true;
   assign differential_clock_output_comp = st_reg.leg_comp;
   assign differential_clock_output_oe_n = st_reg.leg_oe_n;

   ////////////////////////////////////////////////////////////////////////
   sequence pol4_written_s;
      reg_wr && reg_addr == IPC_OFS_OE_POL && reg_wdata[IPC_BIT_EN4];
   endsequence

   // same single-cycle write with the polarity bit cleared, so both levels of enable four are seen
   sequence pol4_cleared_s;
      reg_wr && reg_addr == IPC_OFS_OE_POL && !reg_wdata[IPC_BIT_EN4];
   endsequence

   // pin held low over two edges with no write in between, so the polarity bit is settled
   sequence pin4_low_held_s;
      !output_enable_four && !$past(output_enable_four) && !$past(reg_wr);
   endsequence

   en4_high_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      pol4_written_s ##2 (output_enable_four && $past(output_enable_four)
         && !$past(reg_wr)) |=> output_enabled[3])
      else $error("enable four not active high after polarity set");
   en4_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      pol4_cleared_s ##2 pin4_low_held_s |=> output_enabled[3])
      else $error("enable four not active low after polarity clear");
   en1_level_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_wr && reg_addr == IPC_OFS_OE_POL
      |=> st_reg.oe_pol[IPC_BIT_EN1] == $past(reg_wdata[IPC_BIT_EN1]))
      else $error("enable one polarity bit not written");
   en1_follow_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      $past(nrst) |-> output_enabled[0] ==
         ($past(output_enable_one) == $past(st_reg.oe_pol[IPC_BIT_EN1])))
      else $error("enable one does not follow pin and polarity");
   en23_follow_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      $past(nrst) |-> output_enabled[2:1] ==
         ~({$past(output_enable_three), $past(output_enable_two)} ^
           {$past(st_reg.oe_pol[IPC_BIT_EN3]), $past(st_reg.oe_pol[IPC_BIT_EN2])}))
      else $error("enable two or three polarity wrong");
   pd_follow_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      $past(nrst) |-> power_down ==
         ($past(power_good_power_down_input) == $past(st_reg.pd_pol[IPC_BIT_PD])))
      else $error("power down polarity wrong");
   stop_hiz_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      ($past(nrst) && !$past(st_reg.en[0])
         && $past(disabled_output_state_field) == IPC_STOP_HIZ_HIZ)
      |-> differential_clock_output_oe_n[0])
      else $error("disabled pair not released");
   stop_high_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      ($past(nrst) && !$past(st_reg.en[1])
         && $past(disabled_output_state_field) == IPC_STOP_HIGH_LOW)
      |-> differential_clock_output_true[1] && !differential_clock_output_comp[1])
      else $error("disabled pair not high low");
   reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      (st_reg.oe_pol & ~IPC_OE_POL_MASK) == 8'h00
      && (st_reg.pd_pol & ~IPC_PD_POL_MASK) == 8'h00)
      else $error("reserved bit set");
   read_back_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_rd && reg_addr == IPC_OFS_PD_POL |=> reg_rdata[7:1] == 7'h00)
      else $error("reserved bits read nonzero");

   // write paths: only the documented bits may land, the rest stay zero
   oe_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_wr && reg_addr == IPC_OFS_OE_POL
      |=> st_reg.oe_pol == ($past(reg_wdata) & IPC_OE_POL_MASK))
      else $error("enable polarity write not masked");
   pd_write_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_wr && reg_addr == IPC_OFS_PD_POL
      |=> st_reg.pd_pol == ($past(reg_wdata) & IPC_PD_POL_MASK))
      else $error("power polarity write not masked");

   // read paths: a mapped read returns the register, anything else returns zero
   oe_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_rd && reg_addr == IPC_OFS_OE_POL |=> reg_rdata == $past(st_reg.oe_pol))
      else $error("enable polarity read back wrong");
   unmapped_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
      reg_rd && reg_addr != IPC_OFS_OE_POL && reg_addr != IPC_OFS_PD_POL
      |=> reg_rdata == 8'h00)
      else $error("unmapped read nonzero");

   // first edge out of reset: rose avoids judging the unknown state before any reset edge
   reset_values_a: assert property (@(posedge sys_clk)
      $rose(nrst) |-> st_reg.oe_pol == IPC_OE_POL_RST && st_reg.pd_pol == IPC_PD_POL_RST
         && reg_rdata == 8'h00 && output_enabled == 4'h0 && !power_down
         && differential_clock_output_oe_n == 4'hf)
      else $error("reset values wrong");

   // per pair leg checks; each pair sees the shared stop field one edge late
   generate
      for (genvar p = 0; p < 4; p++)
      begin : g_leg_chk
         stop_low_low_a: assert property (@(posedge sys_clk) disable iff (!nrst)
            ($past(nrst) && !$past(st_reg.en[p])
               && $past(disabled_output_state_field) == IPC_STOP_LOW_LOW)
            |-> !differential_clock_output_true[p] && !differential_clock_output_comp[p]
               && !differential_clock_output_oe_n[p])
            else $error("disabled pair not low low");
         stop_low_high_a: assert property (@(posedge sys_clk) disable iff (!nrst)
            ($past(nrst) && !$past(st_reg.en[p])
               && $past(disabled_output_state_field) == IPC_STOP_LOW_HIGH)
            |-> !differential_clock_output_true[p] && differential_clock_output_comp[p]
               && !differential_clock_output_oe_n[p])
            else $error("disabled pair not low high");
         leg_running_a: assert property (@(posedge sys_clk) disable iff (!nrst)
            ($past(nrst) && $past(st_reg.en[p]))
            |-> !differential_clock_output_oe_n[p]
               && differential_clock_output_true[p] == $past(clock_level[p]))
            else $error("enabled pair not running");
      end
   endgenerate
endmodule : ipc_polarity_regs

// *** bench/ipc_host.sv ***
// Purpose: byte port host standing in for the serial management engine
// Assumes: requests change 1 ns after a rising edge
// Notes: released lines are inverted so a stale value never passes
`timescale 1ns/1ns
module ipc_host
(
   // clock
   input wire logic sys_clk,
   // byte port
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00,
   input wire logic [7:0] reg_rdata
);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask : wr
   // read data is registered at the taking edge, so it is ready 1 ns later
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge sys_clk);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
endmodule : ipc_host

// *** bench/tb_top.sv ***
// Purpose: random self-checking bench of the polarity register pair
// Assumes: pins held three cycles before outputs are judged
// Notes: enabled comp leg is left unchecked, its phase is not fixed
`timescale 1ns/1ns
module tb_top;
   import ipc_pkg::*;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic [3:0] pin = 4'h0;
   logic pgpd = 1'b0;
   logic [1:0] stop = 2'h0;
   logic [3:0] lvl = 4'h0;
   logic reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, a, b, d;
   logic [3:0] en, t, c, o, ee, et, ec, eo;
   logic pd;
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [31:0] seed = 32'h013b;
   ipc_host i_ipc_host (.sys_clk(sys_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   ipc_polarity_regs i_ipc_polarity_regs (.sys_clk(sys_clk), .nrst(nrst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .output_enable_one(pin[0]), .output_enable_two(pin[1]),
      .output_enable_three(pin[2]), .output_enable_four(pin[3]),
      .power_good_power_down_input(pgpd), .disabled_output_state_field(stop),
      .clock_level(lvl), .output_enabled(en), .power_down(pd),
      .differential_clock_output_true(t), .differential_clock_output_comp(c),
      .differential_clock_output_oe_n(o));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   // packs oe_n, comp, true of a disabled or running pair
   function automatic logic [11:0] legs(input logic [3:0] e, input logic [1:0] s,
      input logic [3:0] l);
      logic [11:0] r;
      for (int i = 0; i < 4; i++)
      begin
         r[i] = e[i] ? l[i] : (s == IPC_STOP_HIGH_LOW);
         r[4+i] = !e[i] && (s == IPC_STOP_LOW_HIGH);
         r[8+i] = !e[i] && (s == IPC_STOP_HIZ_HIZ);
      end
      return r;
   endfunction : legs
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk
   task automatic conclude();
      if (n_fail == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end
   // about 400 cycles expected; the ceiling leaves ample margin
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_fail++;
         conclude();
      end
   end
   initial
   begin
      repeat (4) @(posedge sys_clk);
      #1;
      nrst = 1'b1;
      i_ipc_host.rd(IPC_OFS_OE_POL, d);
      chk("oe_pol", 8'h00, d);
      i_ipc_host.rd(IPC_OFS_PD_POL, d);
      chk("pd_pol", 8'h00, d);
      for (int i = 0; i < 24; i++)
      begin
         seed = xs(seed);
         a = (i == 0) ? 8'hff : seed[7:0];
         b = (i == 0) ? 8'hff : seed[15:8];
         i_ipc_host.wr(IPC_OFS_OE_POL, a);
         i_ipc_host.wr(IPC_OFS_PD_POL, b);
         i_ipc_host.wr({3'h1, seed[20:16]}, 8'hff);
         i_ipc_host.rd(IPC_OFS_OE_POL, d);
         chk("oe_pol", a & 8'h6a, d);
         i_ipc_host.rd(IPC_OFS_PD_POL, d);
         chk("pd_pol", b & 8'h01, d);
         i_ipc_host.rd(8'h14, d);
         chk("unmapped", 8'h00, d);
         pin = seed[24:21];
         pgpd = seed[25];
         stop = 2'(i);
         lvl = seed[31:28];
         repeat (3) @(posedge sys_clk);
         #1;
         ee = ~(pin ^ {a[6], a[5], a[3], a[1]});
         chk("enabled", {4'h0, ee}, {4'h0, en});
         chk("power_down", {7'h0, pgpd == b[0]}, {7'h0, pd});
         {eo, ec, et} = legs(ee, stop, lvl);
         chk("true", {4'h0, et}, {4'h0, t});
         chk("comp", {4'h0, ec & ~ee}, {4'h0, c & ~ee});
         chk("oe_n", {4'h0, eo}, {4'h0, o});
      end
      conclude();
   end
endmodule : tb_top
